//--- pse_pkg.sv
/*
  Constants, types and register map of the per-channel status and mode
  register bank of a four-channel PSE group.
  Assumes one 40 MHz clock, a synchronous active-low reset and an I2C host.
*/
package pse_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] PSE_REG_DISC0 = 8'h0C;
  localparam logic [7:0] PSE_REG_PWR = 8'h10;
  localparam logic [7:0] PSE_REG_PIN = 8'h11;
  localparam logic [7:0] PSE_REG_MODE = 8'h12;
  localparam logic [7:0] PSE_REG_ASG0 = 8'h4C;

  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0] PSE_MODE_RST = 8'h00;
  localparam logic [3:0] PSE_FLAG_RST = 4'h0;
  localparam logic [3:0] PSE_CLASS_RST = 4'h0;
  localparam int PSE_PG_LSB = 4;
  localparam int PSE_PE_LSB = 0;
  localparam int PSE_STRAP_LSB = 3;
  localparam int PSE_HALF_POS = 2;
  localparam int PSE_CLASS_LSB = 4;

  // ==========================================================
  // Address and class codes, bit and strap wait counts
  localparam logic [1:0] PSE_ADDR_PREFIX = 2'h1;
  localparam logic [6:0] PSE_ADDR_BCAST = 7'h7F;
  localparam logic [3:0] PSE_CLASS0 = 4'h6;
  localparam logic [3:0] PSE_CLASS3 = 4'h3;
  localparam logic [3:0] PSE_BYTE_BITS = 4'h8;
  localparam logic [1:0] PSE_STRAP_WAIT = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    PSE_MODE_OFF = 2'h0,
    PSE_MODE_MANUAL = 2'h1,
    PSE_MODE_SEMI = 2'h2,
    PSE_MODE_AUTO = 2'h3
  } pse_mode_type;

  typedef enum logic [3:0]
  {
    PSE_ST_IDLE = 4'h0,
    PSE_ST_ADDR = 4'h1,
    PSE_ST_ACK_A = 4'h3,
    PSE_ST_CMD = 4'h2,
    PSE_ST_ACK_C = 4'h6,
    PSE_ST_DATA = 4'h7,
    PSE_ST_ACK_D = 4'h5,
    PSE_ST_RD = 4'h4,
    PSE_ST_RD_ACK = 4'hC
  } pse_state_type;

  typedef struct packed
  {
    logic wired4;
    logic single_sig;
  } pse_port_cfg_type;

endpackage

//--- pse_chan_regs.sv
/*
  Status and mode register bank of four PSE channels with its own I2C target.
  Assumes the detection, class and power engines run on clk and drive the
  channel inputs; SCL, SDA and the strap pins are asynchronous.
*/
`timescale 1ns/10ps
module pse_chan_regs
  import pse_pkg::*;
#(
  parameter logic HALF_SEL = 1'b0,
  parameter logic CONFIG_B = 1'b0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] address_strap_pins,
  input wire pse_port_cfg_type [1:0] port_cfg,
  input wire logic [3:0] chan_on,
  input wire logic [3:0] pg_ok,
  input wire logic [3:0] cls_done,
  input wire logic [3:0][3:0] cls_meas,
  input wire logic [3:0] detect_enable_bit,
  input wire logic [3:0] class_enable_bit,
  input wire logic [3:0] power_on_command,
  output logic [3:0] det_run,
  output logic [3:0] cls_run,
  output logic [3:0] pwr_go,
  output logic [3:0] class_complete_flag,
  output logic [3:0] power_good_change_event,
  output logic [3:0] enable_change_event,
  output logic [7:0] channel_mode_field
);

  // ==========================================================
  // Pin synchronisers
  logic scl_m_reg, scl_s_reg, scl_p_reg;
  logic sda_m_reg, sda_s_reg, sda_p_reg;
  logic [3:0] strap_m_reg, strap_s_reg, strap_reg;
  logic [1:0] strap_cnt_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      strap_m_reg <= 4'h0;
      strap_s_reg <= 4'h0;
    end
    else
    begin
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      scl_p_reg <= scl_s_reg;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
      sda_p_reg <= sda_s_reg;
      strap_m_reg <= address_strap_pins;
      strap_s_reg <= strap_m_reg;
    end
  end

  // Straps are caught once after reset, once the synchroniser has filled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      strap_cnt_reg <= 2'h0;
      strap_reg <= 4'h0;
    end
    else if (strap_cnt_reg != PSE_STRAP_WAIT)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == PSE_STRAP_WAIT - 2'h1)
        strap_reg <= strap_s_reg;
    end
  end

  // ==========================================================
  // Address and register readback
  logic half_bit;
  logic [6:0] own_addr;
  logic [7:0] mode_reg;
  logic [3:0] pe_reg, pg_reg;
  logic [3:0][3:0] req_reg, asg_reg;
  logic [7:0] cmd_reg;
  logic [7:0] rdata;

  assign half_bit = HALF_SEL & ~CONFIG_B;
  assign own_addr = {PSE_ADDR_PREFIX, strap_reg, half_bit};

  always_comb
  begin
    rdata = 8'h00;
    if (cmd_reg == PSE_REG_PWR)
      rdata = {pg_reg, pe_reg};
    else if (cmd_reg == PSE_REG_PIN)
      rdata = {1'b0, strap_reg, half_bit, 2'h0};
    else if (cmd_reg == PSE_REG_MODE)
      rdata = mode_reg;
    else if (cmd_reg[7:2] == PSE_REG_DISC0[7:2])
      rdata = {req_reg[cmd_reg[1:0]], 4'h0};
    else if (cmd_reg[7:2] == PSE_REG_ASG0[7:2])
      rdata = {asg_reg[cmd_reg[1:0]], 4'h0};
  end

  // ==========================================================
  // I2C target: command byte, then one data byte
  pse_state_type state_reg;
  logic [7:0] sh_reg;
  logic [3:0] bit_reg;
  logic rw_reg, wr_mode, sda_oe_reg;
  logic start_c, stop_c, rise_c, fall_c;

  assign start_c = scl_s_reg & sda_p_reg & ~sda_s_reg;
  assign stop_c = scl_s_reg & ~sda_p_reg & sda_s_reg;
  assign rise_c = scl_s_reg & ~scl_p_reg;
  assign fall_c = ~scl_s_reg & scl_p_reg;
  assign wr_mode = fall_c && state_reg == PSE_ST_DATA && bit_reg == PSE_BYTE_BITS && cmd_reg == PSE_REG_MODE;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= PSE_ST_IDLE;
      sh_reg <= 8'h00;
      bit_reg <= 4'h0;
      rw_reg <= 1'b0;
      cmd_reg <= 8'h00;
    end
    else if (start_c)
    begin
      state_reg <= PSE_ST_ADDR;
      bit_reg <= 4'h0;
    end
    else if (stop_c)
      state_reg <= PSE_ST_IDLE;
    else if (rise_c)
    begin
      if (state_reg != PSE_ST_RD)
        sh_reg <= {sh_reg[6:0], sda_s_reg};
      bit_reg <= bit_reg + 4'h1;
    end
    else if (fall_c)
    begin
      bit_reg <= 4'h0;
      unique case (state_reg)
        PSE_ST_IDLE:
          bit_reg <= 4'h0;
        PSE_ST_ADDR:
          if (bit_reg == PSE_BYTE_BITS)
          begin
            rw_reg <= sh_reg[0];
            // Own strapped address or broadcast
            if (sh_reg[7:1] == own_addr || sh_reg[7:1] == PSE_ADDR_BCAST)
              state_reg <= PSE_ST_ACK_A;
            else
              state_reg <= PSE_ST_IDLE;
          end
          else
            bit_reg <= bit_reg;
        PSE_ST_ACK_A:
          if (rw_reg)
          begin
            sh_reg <= rdata;
            state_reg <= PSE_ST_RD;
          end
          else
            state_reg <= PSE_ST_CMD;
        PSE_ST_CMD:
          if (bit_reg == PSE_BYTE_BITS)
          begin
            cmd_reg <= sh_reg;
            state_reg <= PSE_ST_ACK_C;
          end
          else
            bit_reg <= bit_reg;
        PSE_ST_ACK_C:
          state_reg <= PSE_ST_DATA;
        PSE_ST_DATA:
          if (bit_reg == PSE_BYTE_BITS)
            state_reg <= PSE_ST_ACK_D;
          else
            bit_reg <= bit_reg;
        PSE_ST_ACK_D:
          state_reg <= PSE_ST_IDLE;
        PSE_ST_RD:
          if (bit_reg == PSE_BYTE_BITS)
            state_reg <= PSE_ST_RD_ACK;
          else
          begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            bit_reg <= bit_reg;
          end
        PSE_ST_RD_ACK:
          state_reg <= PSE_ST_IDLE;
        default:
          state_reg <= PSE_ST_IDLE;
      endcase
    end
  end

  // Open drain: enable high pulls SDA low
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sda_oe_reg <= 1'b0;
    else
      sda_oe_reg <= state_reg == PSE_ST_ACK_A || state_reg == PSE_ST_ACK_C || state_reg == PSE_ST_ACK_D
                    || (state_reg == PSE_ST_RD && !sh_reg[7]);
  end

  assign sda_oe = sda_oe_reg;
  assign sda_out = 1'b0;

  // ==========================================================
  // Operating mode register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mode_reg <= PSE_MODE_RST;
    else if (wr_mode)
      mode_reg <= sh_reg;
  end

  assign channel_mode_field = mode_reg;

  // ==========================================================
  // Per-channel status, class and command gating
  logic [3:0] pe_new, pg_new, off_c, on_c;

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_ch
      localparam int J = i ^ 1;
      localparam int P = i / 2;
      logic single, moff, same;
      assign single = port_cfg[P].wired4 & port_cfg[P].single_sig;
      assign moff = mode_reg[2*i +: 2] == PSE_MODE_OFF;
      assign same = mode_reg[2*i +: 2] == mode_reg[2*J +: 2];

      // Single signature waits for the partner so only one event fires
      always_comb
      begin
        pe_new[i] = pe_reg[i];
        pg_new[i] = pg_reg[i];
        if (!chan_on[i])
        begin
          pe_new[i] = 1'b0;
          pg_new[i] = 1'b0;
        end
        else if (!single || chan_on[J])
        begin
          pe_new[i] = 1'b1;
          if (pg_ok[i] && (!single || pg_ok[J]))
            pg_new[i] = 1'b1;
        end
      end

      assign off_c[i] = (pe_reg[i] & ~pe_new[i]) | moff;
      assign on_c[i] = pe_new[i] & ~pe_reg[i];

      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          req_reg[i] <= PSE_CLASS_RST;
          asg_reg[i] <= PSE_CLASS_RST;
        end
        else
        begin
          if (off_c[i])
            req_reg[i] <= PSE_CLASS_RST;
          else if (cls_done[i])
            req_reg[i] <= cls_meas[i];
          else if (single && cls_done[J])
            req_reg[i] <= cls_meas[J];
          if (off_c[i])
            asg_reg[i] <= PSE_CLASS_RST;
          else if (on_c[i])
            asg_reg[i] <= (req_reg[i] == PSE_CLASS0) ? PSE_CLASS3 : req_reg[i];
        end
      end

      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          det_run[i] <= 1'b0;
          cls_run[i] <= 1'b0;
          pwr_go[i] <= 1'b0;
        end
        else
        begin
          det_run[i] <= detect_enable_bit[i] & ~moff;
          cls_run[i] <= class_enable_bit[i] & ~moff;
          pwr_go[i] <= power_on_command[i] & ~moff & (~port_cfg[P].wired4 | same);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pe_reg <= PSE_FLAG_RST;
      pg_reg <= PSE_FLAG_RST;
      class_complete_flag <= 4'h0;
      power_good_change_event <= 4'h0;
      enable_change_event <= 4'h0;
    end
    else
    begin
      pe_reg <= pe_new;
      pg_reg <= pg_new;
      class_complete_flag <= cls_done;
      power_good_change_event <= pg_reg & ~pg_new;
      enable_change_event <= pe_reg & ~pe_new;
    end
  end

endmodule

//--- pse_chan_properties.sv
/*
  Concurrent checks on the ports of the PSE status and mode register bank.
  Assumes it is bound to pse_chan_regs and sees only that module's ports.
*/
`timescale 1ns/10ps
module pse_chan_props
  import pse_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire pse_port_cfg_type [1:0] port_cfg,
  input wire logic [3:0] chan_on,
  input wire logic [3:0] cls_done,
  input wire logic [3:0] detect_enable_bit,
  input wire logic [3:0] class_enable_bit,
  input wire logic [3:0] power_on_command,
  input wire logic [3:0] det_run,
  input wire logic [3:0] cls_run,
  input wire logic [3:0] pwr_go,
  input wire logic [3:0] class_complete_flag,
  input wire logic [3:0] power_good_change_event,
  input wire logic [3:0] enable_change_event,
  input wire logic [7:0] channel_mode_field
);
  logic [7:0] m;
  logic [3:0] m_on;
  logic [3:0] m_eq;
  assign m = channel_mode_field;
  assign m_on = {|m[7:6], |m[5:4], |m[3:2], |m[1:0]};
  // Mismatched modes on a wired port block turn-on for both channels
  assign m_eq = {{2{!port_cfg[1].wired4 || m[7:6] == m[5:4]}}, {2{!port_cfg[0].wired4 || m[3:2] == m[1:0]}}};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions
  det_gate_a: assert property (det_run == $past(detect_enable_bit & m_on))
    else $error("detect run does not follow enable and mode");
  cls_gate_a: assert property (cls_run == $past(class_enable_bit & m_on))
    else $error("class run does not follow enable and mode");
  turn_on_a: assert property (pwr_go == $past(power_on_command & m_on & m_eq))
    else $error("turn-on pulse wrong for mode or port pairing");
  cls_flag_a: assert property (class_complete_flag == $past(cls_done))
    else $error("class flag not only on measured channel");
  off_event_a: assert property ($fell(chan_on[0]) && $past(rst_n) && !port_cfg[0].single_sig |-> ##[1:2] enable_change_event[0])
    else $error("no enable change event after turn-off");
  no_event_a: assert property (((power_good_change_event | enable_change_event) & chan_on & $past(chan_on) & $past(chan_on, 2)) == 4'h0)
    else $error("change event while channel stays on");
  event_once_a: assert property (enable_change_event[0] |=> !enable_change_event[0])
    else $error("change event longer than one cycle");
  mode_write_a: assert property ($changed(channel_mode_field) |-> !$past(scl_in))
    else $error("mode register changed outside a data byte");
  sda_drive_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data line changed while clock high");
  pg_event_pair_a: assert property ((power_good_change_event & ~enable_change_event) == 4'h0)
    else $error("power-good change event without enable change event");
  cover property ($fell(chan_on[0]) ##[1:2] enable_change_event[0]);
  cover property (|pwr_go);
  cover property ($changed(channel_mode_field));
  cover property (|power_good_change_event);
endmodule

//--- pse_host_model.sv
/*
  I2C controller model standing for the host processor.
  Assumes SDA is an open-drain wire with a pull-up built by the bench.
*/
`timescale 1ns/10ps
module pse_host_model
(
  input wire logic clk,
  output logic scl,
  output logic sda_h,
  input wire logic sda
);
  initial
  begin
    scl = 1'h1;
    sda_h = 1'h1;
  end
  // ==========================================================
  // Bit level: 6 clock phases keep clear of the 4 clock minimum
  task automatic hp();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic bx(input logic b, output logic r);
    sda_h = b;
    hp();
    scl = 1'h1;
    hp();
    r = sda;
    scl = 1'h0;
    hp();
  endtask
  task automatic start();
    sda_h = 1'h1;
    scl = 1'h1;
    hp();
    sda_h = 1'h0;
    hp();
    scl = 1'h0;
    hp();
  endtask
  task automatic stop();
    sda_h = 1'h0;
    hp();
    scl = 1'h1;
    hp();
    sda_h = 1'h1;
    hp();
  endtask
  // Ninth slot always released: ACK poll on writes, NACK after the read byte
  task automatic bytex(input logic [7:0] d, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
    bx(1'h1, r);
    a = !r;
  endtask
  // ==========================================================
  // Register access: command byte, then one data byte
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic ok);
    logic [7:0] z;
    logic k0, k1, k2;
    start();
    bytex({a, 1'h0}, z, k0);
    bytex(c, z, k1);
    bytex(d, z, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] q, output logic ok);
    logic [7:0] z;
    logic k0, k1, k2, k3;
    start();
    bytex({a, 1'h0}, z, k0);
    bytex(c, z, k1);
    start();
    bytex({a, 1'h1}, z, k2);
    bytex(8'hFF, q, k3);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule

//--- pse_channel_status_mode_regs_test.sv
/*
  Self-checking bench of the PSE status and mode register bank.
  Assumes the host model and the checker are compiled first.
*/
`timescale 1ns/10ps
module pse_channel_status_mode_regs_test;
  import pse_pkg::*;
  localparam logic HS = 1'h0;
  logic clk, rst_n, sda_oe, sda_out, ok, scl, sda_h;
  logic [3:0] straps, chan_on, pg_ok, cls_done, den, cen, pon, det_run, cls_run, pwr_go, ccf, pgce, ece;
  logic [3:0][3:0] meas;
  logic [7:0] mode, q;
  logic [8:0] seen;
  logic [8:0] exp_q[$];
  logic [6:0] dev;
  logic [31:0] rs;
  pse_port_cfg_type [1:0] pcfg;
  int fails = 0, samples_checked = 0, cyc = 0;
  event got;
  // Open drain with pull-up: the device only ever pulls the line to sda_out
  wire sda = sda_h & (!sda_oe | sda_out);
  pse_host_model u_host (.clk(clk), .scl(scl), .sda_h(sda_h), .sda(sda));
  pse_chan_regs #(.HALF_SEL(HS)) u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_strap_pins(straps), .port_cfg(pcfg), .chan_on(chan_on), .pg_ok(pg_ok),
    .cls_done(cls_done), .cls_meas(meas), .detect_enable_bit(den), .class_enable_bit(cen),
    .power_on_command(pon), .det_run(det_run), .cls_run(cls_run), .pwr_go(pwr_go), .class_complete_flag(ccf),
    .power_good_change_event(pgce), .enable_change_event(ece), .channel_mode_field(mode));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [8:0] s, input logic [8:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Expected value is queued before the bus cycle; watcher compares on arrival
  task automatic rq(input logic [6:0] a, input logic [7:0] c, input logic [8:0] e);
    exp_q.push_back(e);
    u_host.rd(a, c, q, ok);
    seen = {ok, q};
    ->got;
  endtask
  task automatic wq(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
    exp_q.push_back(9'h001);
    u_host.wr(a, c, d, ok);
    seen = {8'h00, ok};
    ->got;
  endtask
  task automatic pulse(ref logic [3:0] s, input logic [3:0] v);
    s = v;
    tk(1);
    s = 4'h0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(got)
    check(seen, exp_q.pop_front());
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = !clk;
  end
  initial
  begin
    rst_n = 1'h0;
    rs = xs(32'h0000_9b3a);
    straps = rs[3:0];
    pcfg = 4'h2;
    {chan_on, pg_ok, cls_done, pon} = 16'h0000;
    meas = 16'h0000;
    den = 4'hF;
    cen = rs[7:4];
    dev = {PSE_ADDR_PREFIX, straps, HS};
    tk(8);
    rst_n = 1'h1;
    tk(6);
    rq(dev, PSE_REG_PWR, 9'h100);
    rq(dev, PSE_REG_MODE, 9'h100);
    rq(dev, PSE_REG_PIN, {1'h1, 1'h0, straps, HS, 2'h0});
    rs = xs(rs);
    wq(PSE_ADDR_BCAST, PSE_REG_MODE, rs[7:0]);
    rq(dev, PSE_REG_MODE, {1'h1, rs[7:0]});
    rq(dev ^ 7'h02, PSE_REG_MODE, 9'h0FF);
    rq(dev, 8'h20, 9'h100);
    wq(dev, PSE_REG_PWR, 8'hFF);
    rq(dev, PSE_REG_PWR, 9'h100);
    $display("reset and access tests done");
    for (int m = 0; m < 4; m++)
    begin
      wq(dev, PSE_REG_MODE, {4{m[1:0]}});
      pulse(pon, 4'hF);
      rq(dev, PSE_REG_MODE, {1'h1, {4{m[1:0]}}});
    end
    wq(dev, PSE_REG_MODE, 8'hF7);
    pulse(pon, 4'h1);
    wq(dev, PSE_REG_MODE, 8'hFF);
    $display("mode tests done");
    pcfg = 4'hE;
    rs = xs(rs);
    // Class 0 is measured on the third channel; it and its single-signature partner report it
    meas = {4'h0, PSE_CLASS0, 4'h0, 4'h1 + rs[1:0]};
    pulse(cls_done, 4'h5);
    rq(dev, 8'h0C, {1'h1, meas[0], 4'h0});
    rq(dev, 8'h0D, 9'h100);
    rq(dev, 8'h0E, 9'h160);
    rq(dev, 8'h0F, 9'h160);
    $display("class tests done");
    chan_on = 4'h1;
    pg_ok = 4'h1;
    rq(dev, PSE_REG_PWR, 9'h111);
    chan_on = 4'h3;
    rq(dev, PSE_REG_PWR, 9'h113);
    rq(dev, PSE_REG_ASG0, {1'h1, meas[0], 4'h0});
    chan_on = 4'h2;
    rq(dev, PSE_REG_PWR, 9'h102);
    rq(dev, 8'h0C, 9'h100);
    chan_on = 4'h6;
    rq(dev, PSE_REG_PWR, 9'h102);
    chan_on = 4'hE;
    rq(dev, PSE_REG_PWR, 9'h10E);
    rq(dev, 8'h4E, 9'h130);
    rq(dev, 8'h4F, 9'h130);
    rq(dev, 8'h0E, 9'h160);
    wq(dev, PSE_REG_MODE, 8'h00);
    pulse(pon, 4'hF);
    rq(dev, 8'h0E, 9'h100);
    $display("power status tests done");
    chan_on = 4'h0;
    rst_n = 1'h0;
    tk(8);
    rst_n = 1'h1;
    tk(6);
    rq(dev, PSE_REG_MODE, 9'h100);
    rq(dev, PSE_REG_PWR, 9'h100);
    // Let the watcher take the last result before the verdict
    tk(1);
    $display("second reset test done");
    conclude();
  end
endmodule
bind pse_chan_regs pse_chan_props u_props (.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_oe(sda_oe),
  .port_cfg(port_cfg), .chan_on(chan_on), .cls_done(cls_done), .detect_enable_bit(detect_enable_bit),
  .class_enable_bit(class_enable_bit), .power_on_command(power_on_command), .det_run(det_run), .cls_run(cls_run),
  .pwr_go(pwr_go), .class_complete_flag(class_complete_flag), .power_good_change_event(power_good_change_event),
  .enable_change_event(enable_change_event), .channel_mode_field(channel_mode_field));
